// ==== hdl/fnds_settings.sv ====
// Divider settings bank of a fractional-N synthesizer with its reference divider.
// Assumes a classic Wishbone master on sys_clk and a reference input synchronous to it.
// Overview of operation
// - Reference input is divided by the 12-bit reference value into comparison ticks.
// - With the doubler on, every rising reference edge passes; the divider is bypassed.
// - Integer mode feedback value is 18 bits from two separate fields.
// - Fractional mode uses only the low twelve feedback bits.
// - 22-bit numerator assembled from two registers, applied in fractional mode only.
// - A 22-bit denominator 0 through 4194303 is held for fractional mode.
// - Every write to lowest control word starts calibration when internal oscillator used.
// - Reference, feedback and numerator fields sit in the two lowest words, split.
`include "fnds_cfg.svh"
module fnds_settings (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic refOscInput,
    output logic compTick,
    output logic [17:0] feedbackDiv,
    output logic [21:0] fracNumerator,
    output logic [21:0] fracDenominator,
    output logic fracMode,
    output logic [1:0] modOrder,
    output logic calStart,
    output logic calBusy
);
    // ====================================================================
    // Limit functions
    function automatic logic [17:0] nMinimum(input logic [1:0] ord, input logic frac);
        if (!frac) begin
            nMinimum = `FNDS_NMIN_1;
        end else if (ord == fnds_pkg::FNDS_ORD2) begin
            nMinimum = `FNDS_NMIN_2;
        end else if (ord == fnds_pkg::FNDS_ORD3) begin
            nMinimum = `FNDS_NMIN_3;
        end else if (ord == fnds_pkg::FNDS_ORD4) begin
            nMinimum = `FNDS_NMIN_4;
        end else begin
            nMinimum = `FNDS_NMIN_1;
        end
    endfunction

    function automatic logic [17:0] nMaximum(input logic [1:0] ord);
        if (ord == fnds_pkg::FNDS_ORD2) begin
            nMaximum = `FNDS_NMAX_2;
        end else if (ord == fnds_pkg::FNDS_ORD3) begin
            nMaximum = `FNDS_NMAX_3;
        end else if (ord == fnds_pkg::FNDS_ORD4) begin
            nMaximum = `FNDS_NMAX_4;
        end else begin
            nMaximum = `FNDS_NMAX_1;
        end
    endfunction

    // ====================================================================
    // Wishbone slave
    logic ack_r;
    logic [31:0] rdat_r;
    logic writeNow;
    logic [11:0] refDiv_r;
    logic [11:0] nLow_r;
    logic [5:0] nHigh_r;
    logic [15:0] numLow_r;
    logic [5:0] numHigh_r;
    logic [21:0] denom_r;
    logic [4:0] ctrl_r;
    logic [4:0] status;
    logic [17:0] feedback_nxt;
    logic [21:0] numer_nxt;
    fnds_pkg::fnds_cal_e calState_r;
    logic [7:0] calCnt_r;
    logic refLast_r;

    // Writes take effect only on the acknowledging edge, so the master sees one write per cycle.
    assign writeNow = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdat_r <= 32'h0000_0000;
        end else if (wb_adr_i == `FNDS_OFS_WORD0) begin
            rdat_r <= {4'h0, numLow_r, nLow_r};
        end else if (wb_adr_i == `FNDS_OFS_WORD1) begin
            rdat_r <= {8'h00, numHigh_r, nHigh_r, refDiv_r};
        end else if (wb_adr_i == `FNDS_OFS_DENOM) begin
            rdat_r <= {10'h000, denom_r};
        end else if (wb_adr_i == `FNDS_OFS_CTRL) begin
            rdat_r <= {27'h0000000, ctrl_r};
        end else if (wb_adr_i == `FNDS_OFS_STAT) begin
            rdat_r <= {27'h0000000, status};
        end else begin
            rdat_r <= 32'h0000_0000;
        end
    end

    // ====================================================================
    // Setting registers; byte enables are honoured lane by lane.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            nLow_r <= `FNDS_RST_NLO;
            numLow_r <= 16'h0000;
        end else if (writeNow && wb_adr_i == `FNDS_OFS_WORD0) begin
            if (wb_sel_i[0]) nLow_r[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) nLow_r[11:8] <= wb_dat_i[11:8];
            if (wb_sel_i[1]) numLow_r[3:0] <= wb_dat_i[15:12];
            if (wb_sel_i[2]) numLow_r[11:4] <= wb_dat_i[23:16];
            if (wb_sel_i[3]) numLow_r[15:12] <= wb_dat_i[27:24];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            refDiv_r <= `FNDS_RST_R;
            nHigh_r <= 6'h00;
            numHigh_r <= 6'h00;
        end else if (writeNow && wb_adr_i == `FNDS_OFS_WORD1) begin
            if (wb_sel_i[0]) refDiv_r[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) refDiv_r[11:8] <= wb_dat_i[11:8];
            if (wb_sel_i[1]) nHigh_r[3:0] <= wb_dat_i[15:12];
            if (wb_sel_i[2]) nHigh_r[5:4] <= wb_dat_i[17:16];
            if (wb_sel_i[2]) numHigh_r[5:0] <= wb_dat_i[23:18];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            denom_r <= 22'h000000;
        end else if (writeNow && wb_adr_i == `FNDS_OFS_DENOM) begin
            if (wb_sel_i[0]) denom_r[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) denom_r[15:8] <= wb_dat_i[15:8];
            if (wb_sel_i[2]) denom_r[21:16] <= wb_dat_i[21:16];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_r <= `FNDS_RST_CTRL;
        end else if (writeNow && wb_adr_i == `FNDS_OFS_CTRL && wb_sel_i[0]) begin
            ctrl_r <= wb_dat_i[4:0];
        end
    end

    // ====================================================================
    // Effective divider values
    always_comb begin
        if (ctrl_r[`FNDS_CTRL_FRAC]) begin
            feedback_nxt = {6'h00, nLow_r};
            numer_nxt = {numHigh_r, numLow_r};
        end else begin
            feedback_nxt = {nHigh_r, nLow_r};
            numer_nxt = 22'h000000;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            feedbackDiv <= {6'h00, `FNDS_RST_NLO};
            fracNumerator <= 22'h000000;
            fracDenominator <= 22'h000000;
            fracMode <= 1'b0;
            modOrder <= 2'h0;
        end else begin
            feedbackDiv <= feedback_nxt;
            fracNumerator <= numer_nxt;
            fracDenominator <= denom_r;
            fracMode <= ctrl_r[`FNDS_CTRL_FRAC];
            modOrder <= ctrl_r[`FNDS_CTRL_ORD_LSB +: 2];
        end
    end

    // Illegal host settings are flagged, not corrected; the divider still runs on them.
    assign status[`FNDS_ST_CALBUSY] = calBusy;
    assign status[`FNDS_ST_RBAD] = (refDiv_r == 12'h000);
    assign status[`FNDS_ST_NLOW] = feedback_nxt < nMinimum(ctrl_r[2:1], ctrl_r[0]);
    assign status[`FNDS_ST_NHIGH] = ctrl_r[0] && (feedback_nxt > nMaximum(ctrl_r[2:1]));
    assign status[`FNDS_ST_NUMBAD] = ctrl_r[0] && ({numHigh_r, numLow_r} > denom_r);

    // ====================================================================
    // Oscillator calibration; a new write restarts a running calibration.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            calStart <= 1'b0;
            calState_r <= fnds_pkg::FNDS_CAL_IDLE;
            calCnt_r <= 8'h00;
        end else begin
            calStart <= writeNow && wb_adr_i == `FNDS_OFS_WORD0 && ctrl_r[`FNDS_CTRL_INTOSC];
            if (writeNow && wb_adr_i == `FNDS_OFS_WORD0 && ctrl_r[`FNDS_CTRL_INTOSC]) begin
                calState_r <= fnds_pkg::FNDS_CAL_RUN;
                calCnt_r <= 8'(`FNDS_CAL_CYCLES - 1);
            end else begin
                case (calState_r)
                    fnds_pkg::FNDS_CAL_RUN: begin
                        if (calCnt_r == 8'h00) calState_r <= fnds_pkg::FNDS_CAL_IDLE;
                        else calCnt_r <= calCnt_r - 8'h01;
                    end
                    default: begin
                        calCnt_r <= 8'h00;
                    end
                endcase
            end
        end
    end
    assign calBusy = (calState_r == fnds_pkg::FNDS_CAL_RUN);

    // ====================================================================
    // Reference divider
    fnds_div_if dvIf ();

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            refLast_r <= 1'b0;
        end else begin
            refLast_r <= refOscInput;
        end
    end
    assign dvIf.refTick = refOscInput && !refLast_r;
    assign dvIf.bypass = ctrl_r[`FNDS_CTRL_DBL];
    assign dvIf.divValue = refDiv_r;
    assign compTick = dvIf.compTick;

    fnds_ref_divider uDiv (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .dv(dvIf.div)
    );

    // ====================================================================
    // Checks
    a_int_feedback: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !ctrl_r[0] |=> feedbackDiv == {$past(nHigh_r), $past(nLow_r)})
        else $error("Integer feedback value not assembled from both fields.");
    a_frac_feedback: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ctrl_r[0] |=> feedbackDiv[17:12] == 6'h00 && feedbackDiv[11:0] == $past(nLow_r))
        else $error("Fractional feedback used upper bits.");
    a_num_apply: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ctrl_r[0] |=> fracNumerator == {$past(numHigh_r), $past(numLow_r)})
        else $error("Numerator not applied in fractional mode.");
    a_num_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !ctrl_r[0] |=> fracNumerator == 22'h000000)
        else $error("Numerator applied in integer mode.");
    a_denom_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        writeNow && wb_adr_i == `FNDS_OFS_DENOM && wb_sel_i == 4'hF
        |=> ##1 fracDenominator == $past(wb_dat_i[21:0], 2))
        else $error("Denominator write lost.");
    a_cal_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
        writeNow && wb_adr_i == `FNDS_OFS_WORD0 && ctrl_r[4] |=> calStart && calBusy)
        else $error("Lowest word write did not start calibration.");
    a_word1_split: assert property (@(posedge sys_clk) disable iff (!rst_n)
        writeNow && wb_adr_i == `FNDS_OFS_WORD1 && wb_sel_i == 4'hF
        |=> refDiv_r == $past(wb_dat_i[11:0]) && nHigh_r == $past(wb_dat_i[17:12]))
        else $error("Second word fields misplaced.");
    a_comp_source: assert property (@(posedge sys_clk) disable iff (!rst_n)
        compTick |-> $past(dvIf.refTick))
        else $error("Comparison tick without reference edge.");
endmodule

// ==== hdl/fnds_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the divider settings bank.
// Assumes a 32-bit classic Wishbone slave clocked by sys_clk at 25 MHz.
`ifndef FNDS_CFG_SVH
`define FNDS_CFG_SVH
// ========================================================================
// Register byte offsets
`define FNDS_OFS_WORD0 8'h00
`define FNDS_OFS_WORD1 8'h04
`define FNDS_OFS_DENOM 8'h08
`define FNDS_OFS_CTRL 8'h0C
`define FNDS_OFS_STAT 8'h10
// ========================================================================
// Field positions of the two lowest control words
`define FNDS_W0_NLO_LSB 0
`define FNDS_W0_NUMLO_LSB 12
`define FNDS_W1_R_LSB 0
`define FNDS_W1_NHI_LSB 12
`define FNDS_W1_NUMHI_LSB 18
// ========================================================================
// Control and status bit positions
`define FNDS_CTRL_FRAC 0
`define FNDS_CTRL_ORD_LSB 1
`define FNDS_CTRL_DBL 3
`define FNDS_CTRL_INTOSC 4
`define FNDS_ST_CALBUSY 0
`define FNDS_ST_RBAD 1
`define FNDS_ST_NLOW 2
`define FNDS_ST_NHIGH 3
`define FNDS_ST_NUMBAD 4
// ========================================================================
// Reset values and limits
`define FNDS_RST_R 12'h001
`define FNDS_RST_NLO 12'h00C
`define FNDS_RST_CTRL 5'h00
`define FNDS_NMIN_1 18'h0000C
`define FNDS_NMIN_2 18'h0000D
`define FNDS_NMIN_3 18'h0000F
`define FNDS_NMIN_4 18'h00013
`define FNDS_NMAX_1 18'h00FFE
`define FNDS_NMAX_2 18'h00FFD
`define FNDS_NMAX_3 18'h00FFB
`define FNDS_NMAX_4 18'h00FF7
// ========================================================================
// Calibration time in ns and its length in sys_clk cycles
`define FNDS_CAL_NS 4000
`define FNDS_CLK_NS 40
`define FNDS_CAL_CYCLES ((`FNDS_CAL_NS + `FNDS_CLK_NS - 1) / `FNDS_CLK_NS)
`endif

// ==== hdl/fnds_pkg.sv ====
// Types shared by the divider settings bank.
// Assumes fnds_cfg.svh supplies all numeric constants.
package fnds_pkg;
    typedef enum logic [1:0] {
        FNDS_ORD1 = 2'h0,
        FNDS_ORD2 = 2'h1,
        FNDS_ORD3 = 2'h2,
        FNDS_ORD4 = 2'h3
    } fnds_order_e;
    typedef enum logic {
        FNDS_CAL_IDLE = 1'b0,
        FNDS_CAL_RUN = 1'b1
    } fnds_cal_e;
endpackage

// ==== hdl/fnds_div_if.sv ====
// Carries the reference divider settings and its comparison tick.
// Assumes both ends run on the same sys_clk.
interface fnds_div_if;
    logic refTick;
    logic bypass;
    logic [11:0] divValue;
    logic compTick;
    modport ctrl (output refTick, output bypass, output divValue, input compTick);
    modport div (input refTick, input bypass, input divValue, output compTick);
endinterface

// ==== hdl/fnds_ref_divider.sv ====
// Reference divider: turns reference edges into comparison ticks.
// Assumes refTick is a one-cycle pulse per reference rising edge.
module fnds_ref_divider (
    input wire logic sys_clk,
    input wire logic rst_n,
    fnds_div_if.div dv
);
    logic [11:0] cnt_r;
    logic tick_r;
    logic lastCount;

    // A divide value of zero is never legal; it behaves as one so the counter cannot run away.
    assign lastCount = (cnt_r + 12'h001 >= dv.divValue);
    assign dv.compTick = tick_r;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt_r <= 12'h000;
        end else if (dv.refTick) begin
            cnt_r <= (dv.bypass || lastCount) ? 12'h000 : cnt_r + 12'h001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= dv.refTick && (dv.bypass || lastCount);
        end
    end

    a_div_terminal: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dv.refTick && !dv.bypass && (cnt_r == dv.divValue - 12'h001) |=> tick_r)
        else $error("Comparison tick missing at terminal count.");
    a_div_early: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dv.refTick && !dv.bypass && (cnt_r + 12'h001 < dv.divValue) |=> !tick_r)
        else $error("Comparison tick before terminal count.");
    a_div_bypass: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dv.refTick && dv.bypass |=> tick_r)
        else $error("Bypassed divider dropped a reference edge.");
endmodule

// ==== verification/fnds_ref_source.sv ====
// Reference oscillator model that drives the settings bank's reference input.
// Assumes sys_clk is the bench clock; the level changes just after rising edges.
module fnds_ref_source (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic runEn,
    input wire logic [3:0] halfPeriod,
    output logic refOscInput
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] phaseCnt;
    // ========================================================================
    // Square wave
    // A half period of at least one cycle keeps rising edges at least two clocks apart.
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !runEn) begin
            phaseCnt <= 4'h0;
            refOscInput <= 1'b0;
        end else if (phaseCnt + 4'h1 >= halfPeriod) begin
            phaseCnt <= 4'h0;
            refOscInput <= ~refOscInput;
        end else begin
            phaseCnt <= phaseCnt + 4'h1;
        end
    end
endmodule

// ==== verification/test_frac_n_divider_settings.sv ====
// Self-checking bench of the divider settings bank over classic Wishbone.
// Assumes the bank answers each request after one cycle and that outputs are registered.
`include "fnds_cfg.svh"
module test_frac_n_divider_settings;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] adr;
        logic [31:0] wdat;
        logic [31:0] rexp;
    } fnds_row_s;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [31:0] wbDatW = 32'h00000000;
    logic [31:0] wbDatR;
    logic wbAck;
    logic refOsc;
    logic refRun = 1'b0;
    logic compTick, fracMode, calStart, calBusy;
    logic [17:0] feedbackDiv;
    logic [21:0] fracNumerator, fracDenominator;
    logic [1:0] modOrder;
    logic [31:0] rd;
    int badCount = 0;
    int checked = 0;
    int calCount = 0;
    int gap, c0;
    fnds_row_s rows [6] = '{
        '{`FNDS_OFS_WORD0, 32'hFABCD123, 32'h0ABCD123},
        '{`FNDS_OFS_WORD1, 32'hFFFFF005, 32'h00FFF005},
        '{`FNDS_OFS_DENOM, 32'hFFFFFFFF, 32'h003FFFFF},
        '{`FNDS_OFS_CTRL, 32'hFFFFFFE6, 32'h00000006},
        '{8'h20, 32'hFFFFFFFF, 32'h00000000},
        '{8'hFC, 32'h12345678, 32'h00000000}};

    fnds_settings i_fnds_settings (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF),
        .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .refOscInput(refOsc),
        .compTick(compTick), .feedbackDiv(feedbackDiv), .fracNumerator(fracNumerator),
        .fracDenominator(fracDenominator), .fracMode(fracMode), .modOrder(modOrder),
        .calStart(calStart), .calBusy(calBusy));
    fnds_ref_source i_fnds_ref_source (.sys_clk(sys_clk), .rst_n(rst_n), .runEn(refRun),
        .halfPeriod(4'h2), .refOscInput(refOsc));

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (calStart === 1'b1) calCount++;
    end

    task complete_run();
        $display("checked %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] expv, input string what);
        checked++;
        if (seen !== expv) begin
            badCount++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, expv);
        end
    endtask
    task timedOut(input string what);
        badCount++;
        $display("CHECK FAILED at %0t: %s", $time, what);
        complete_run();
    endtask
    // ========================================================================
    // Bus cycles
    task wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                output logic [31:0] rdat);
        int n;
        n = 0;
        @(posedge sys_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatW <= dat;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        if (wbAck !== 1'b1) timedOut("no acknowledge");
        rdat = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask
    task wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] dummy;
        wbXfer(1'b1, adr, dat, dummy);
    endtask
    task measureGap(output int g);
        int n;
        n = 0;
        g = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (compTick !== 1'b1 && n < 200);
        do begin
            @(posedge sys_clk);
            g++;
        end while (compTick !== 1'b1 && g < 200);
        if (n >= 200 || g >= 200) timedOut("no comparison tick");
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        check({14'h0, feedbackDiv}, 32'h0000000C, "reset feedback");
        check({10'h0, fracDenominator}, 32'h0, "reset denominator");
        wbXfer(1'b0, `FNDS_OFS_WORD1, 32'h0, rd);
        check(rd, 32'h00000001, "reset word1");
        foreach (rows[i]) begin
            wr(rows[i].adr, rows[i].wdat);
            wbXfer(1'b0, rows[i].adr, 32'h0, rd);
            check(rd, rows[i].rexp, "readback");
        end
        repeat (2) @(posedge sys_clk);
        check({14'h0, feedbackDiv}, 32'h0003F123, "integer feedback");
        check({10'h0, fracNumerator}, 32'h0, "integer numerator");
        check({10'h0, fracDenominator}, 32'h003FFFFF, "denominator");
        check({30'h0, modOrder}, 32'h3, "order");
        wr(`FNDS_OFS_CTRL, 32'h00000007);
        repeat (2) @(posedge sys_clk);
        check({31'h0, fracMode}, 32'h1, "fractional mode");
        check({14'h0, feedbackDiv}, 32'h00000123, "fractional feedback");
        check({10'h0, fracNumerator}, 32'h003FABCD, "numerator");
        // Reference period is four clocks, so the tick gap is four times the divide value.
        refRun <= 1'b1;
        measureGap(gap);
        check(gap, 32'd20, "divide by five");
        wr(`FNDS_OFS_CTRL, 32'h0000000F);
        measureGap(gap);
        measureGap(gap);
        check(gap, 32'd4, "doubler bypass");
        wr(`FNDS_OFS_CTRL, 32'h00000007);
        wr(`FNDS_OFS_WORD1, 32'h00FFF000);
        measureGap(gap);
        measureGap(gap);
        check(gap, 32'd4, "zero divide value");
        wbXfer(1'b0, `FNDS_OFS_STAT, 32'h0, rd);
        check(rd & 32'h00000002, 32'h00000002, "zero divide flag");
        refRun <= 1'b0;
        // Calibration runs on every lowest word write with the internal oscillator on, also with an unchanged value.
        wr(`FNDS_OFS_CTRL, 32'h00000017);
        c0 = calCount;
        wr(`FNDS_OFS_WORD0, 32'h0ABCD123);
        repeat (3) @(posedge sys_clk);
        check({31'h0, calBusy}, 32'h1, "calibration busy");
        wr(`FNDS_OFS_WORD0, 32'h0ABCD123);
        repeat (3) @(posedge sys_clk);
        check(calCount - c0, 32'd2, "calibration starts");
        gap = 0;
        while (calBusy === 1'b1 && gap < 300) begin
            @(posedge sys_clk);
            gap++;
        end
        // Three busy cycles passed before the loop, which stops one edge after busy falls.
        check(gap, `FNDS_CAL_CYCLES - 2, "cal length");
        wr(`FNDS_OFS_CTRL, 32'h00000007);
        c0 = calCount;
        wr(`FNDS_OFS_WORD0, 32'h0ABCD123);
        repeat (3) @(posedge sys_clk);
        check(calCount - c0, 32'd0, "no calibration");
        // Host limit flags: feedback below the fourth order minimum, above the second
        // order maximum, then a numerator above the denominator.
        wr(`FNDS_OFS_WORD0, 32'h0ABCD012);
        wbXfer(1'b0, `FNDS_OFS_STAT, 32'h0, rd);
        check(rd, 32'h00000006, "feedback below minimum");
        wr(`FNDS_OFS_CTRL, 32'h00000003);
        wr(`FNDS_OFS_WORD0, 32'h0ABCDFFE);
        wbXfer(1'b0, `FNDS_OFS_STAT, 32'h0, rd);
        check(rd, 32'h0000000A, "feedback above maximum");
        wr(`FNDS_OFS_DENOM, 32'h003FABCC);
        wbXfer(1'b0, `FNDS_OFS_STAT, 32'h0, rd);
        check(rd, 32'h0000001A, "numerator above denominator");
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        check({14'h0, feedbackDiv}, 32'h0000000C, "second reset");
        check({31'h0, fracMode}, 32'h0, "second reset mode");
        wbXfer(1'b0, `FNDS_OFS_WORD1, 32'h0, rd);
        check(rd, 32'h00000001, "second reset word1");
        complete_run();
    end
endmodule
